// ===== hdl/cwd_pkg.sv
// package: register map, field layout, reset values and carriers for cwd
package cwd_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned NWIN = 2;
  localparam logic [7:0] MEM_LO_IDX [NWIN] = '{8'h1c, 8'h24};
  localparam logic [7:0] MEM_HI_IDX [NWIN] = '{8'h20, 8'h28};
  localparam logic [7:0] IO_LO_IDX [NWIN] = '{8'h2c, 8'h34};
  localparam logic [7:0] IO_HI_IDX [NWIN] = '{8'h30, 8'h38};
  localparam logic [7:0] IRQ_LINE_IDX = 8'h3c;
  localparam logic [7:0] IRQ_PIN_IDX = 8'h3d;
  localparam logic [7:0] BRIDGE_CTL_IDX = 8'h3e;
  localparam logic [7:0] DEV_CTL_IDX = 8'h92;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned MEM_LSB = 12;
  localparam int unsigned IO_LSB = 2;
  localparam int unsigned IO_HI_MSB = 15;
  localparam int unsigned IO_PAGE_LSB = 16;
  localparam int unsigned PREF0_BIT = 8;
  localparam int unsigned PREF1_BIT = 9;
  localparam int unsigned MODE_LSB = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [19:0] MEM_RST = 20'h00000;
  localparam logic [29:0] IO_LO_RST = 30'h00000000;
  localparam logic [13:0] IO_HI_RST = 14'h0000;
  localparam logic [7:0] IRQ_LINE_RST = 8'hff;
  localparam logic [1:0] PREF_RST = 2'h3;
  localparam logic [7:0] PIN_INTA = 8'h01;
  localparam logic [7:0] PIN_NONE = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_isa_parallel_only,
    mode_parallel_both,
    mode_serial_isa_parallel_pci,
    mode_serial_both
  } cwd_irq_mode_e;

  localparam cwd_irq_mode_e MODE_RST = mode_serial_both;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } cwd_req_s;

  typedef struct packed {
    logic valid;
    logic fwd;
    logic win;
    logic prefetchable;
  } cwd_dec_s;

  function automatic logic [11:0] cwd_byte_addr(input logic [7:0] idx);
    cwd_byte_addr = {2'h0, idx, 2'h0};
  endfunction : cwd_byte_addr

endpackage : cwd_pkg

// ===== hdl/cwd_window_decode.sv
// cwd_window_decode: cardbus window registers and forward decode
//
// What this block does
// - two writable 4k-aligned memory window bases
// - memory window low twelve bits read zero
// - two memory window limits, same layout
// - memory windows steer both forwarding directions
// - memory window off while base, limit zero
// - window prefetch type from bridge bits 8,9
// - two io bases: page plus offset
// - io base bits 31..2 writable, 1..0 zero
// - io window off while base, limit zero
// - two io limits, bits 15..2 writable
// - io limit upper half, low bits zero
// - io limit low two bits compare as ones
// - io windows steer both forwarding directions
// - interrupt line byte, writable, resets ff
// - interrupt pin read-only, follows signalling mode
// - reset into serialized pci and isa mode
// - prefetch bit one means prefetchable, default
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cwd_window_decode (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // pci side decode request and answer
  input wire cwd_pkg::cwd_req_s pci_req,
  output cwd_pkg::cwd_dec_s pci_dec,
  // cardbus side decode request and answer
  input wire cwd_pkg::cwd_req_s cb_req,
  output cwd_pkg::cwd_dec_s cb_dec,
  // configuration views
  output logic window0_prefetchable,
  output logic window1_prefetchable,
  output cwd_pkg::cwd_irq_mode_e irq_mode
);

  // ---------------------------------------------------------------
  // bus phases and byte-lane merge
  // ---------------------------------------------------------------
  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic wr_en = access_ph & pwrite;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ---------------------------------------------------------------
  // shared registers
  // ---------------------------------------------------------------
  logic [7:0] irq_line_q, irq_line_d;
  logic [1:0] pref_q, pref_d;
  cwd_pkg::cwd_irq_mode_e mode_q, mode_d;
  logic [31:0] prdata_q, prdata_d;
  cwd_pkg::cwd_dec_s pci_dec_q, pci_dec_d, cb_dec_q, cb_dec_d;

  wire logic sel_line =
    paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::IRQ_LINE_IDX);
  wire logic sel_pin =
    paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::IRQ_PIN_IDX);
  wire logic sel_bctl =
    paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::BRIDGE_CTL_IDX);
  wire logic sel_dctl =
    paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::DEV_CTL_IDX);

  wire logic [31:0] line_view = {24'h000000, irq_line_q};
  wire logic [31:0] bctl_view = {22'h000000, pref_q, 8'h00};
  wire logic [31:0] dctl_view = {29'h00000000, mode_q, 1'b0};
  // no pci interrupt in isa-only mode, so the pin reads as unused
  wire logic [7:0] pin_val =
    (mode_q == cwd_pkg::mode_isa_parallel_only) ?
    cwd_pkg::PIN_NONE : cwd_pkg::PIN_INTA;
  wire logic [31:0] pin_view = {24'h000000, pin_val};

  wire logic [31:0] line_m = merge(line_view, pwdata, pstrb);
  wire logic [31:0] bctl_m = merge(bctl_view, pwdata, pstrb);
  wire logic [31:0] dctl_m = merge(dctl_view, pwdata, pstrb);

  assign irq_line_d = (wr_en & sel_line) ? line_m[7:0] : irq_line_q;
  assign pref_d = (wr_en & sel_bctl) ?
    bctl_m[cwd_pkg::PREF1_BIT:cwd_pkg::PREF0_BIT] : pref_q;
  assign mode_d = (wr_en & sel_dctl) ?
    cwd_pkg::cwd_irq_mode_e'(dctl_m[cwd_pkg::MODE_LSB +: 2]) : mode_q;

  // ---------------------------------------------------------------
  // per-window registers and decode
  // ---------------------------------------------------------------
  logic [19:0] mem_lo_q [2];
  logic [19:0] mem_hi_q [2];
  logic [29:0] io_lo_q [2];
  logic [13:0] io_hi_q [2];
  logic [1:0] sel_mem_lo, sel_mem_hi, sel_io_lo, sel_io_hi;
  logic [31:0] mem_lo_view [2];
  logic [31:0] mem_hi_view [2];
  logic [31:0] io_lo_view [2];
  logic [31:0] io_hi_view [2];
  logic [1:0] pci_mem_hit, pci_io_hit, cb_mem_hit, cb_io_hit;

  // ---------------------------------------------------------------
  // check clocking and shared sequences
  // ---------------------------------------------------------------
  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_full_wr(logic sel);
    wr_en && sel && pstrb == 4'hf;
  endsequence

  for (genvar w = 0; w < 2; w++) begin : g_win
    wire logic [31:0] mem_base = {mem_lo_q[w], 12'h000};
    wire logic [31:0] mem_top = {mem_hi_q[w], 12'hfff};
    wire logic [31:0] io_base = {io_lo_q[w], 2'b00};
    // page from the base, offset from the limit, low bits as ones
    wire logic [31:0] io_top =
      {io_lo_q[w][29:14], io_hi_q[w], 2'b11};
    wire logic mem_on = |{mem_lo_q[w], mem_hi_q[w]};
    wire logic io_on = |{io_lo_q[w], io_hi_q[w]};

    wire logic [31:0] mlo_m = merge(mem_lo_view[w], pwdata, pstrb);
    wire logic [31:0] mhi_m = merge(mem_hi_view[w], pwdata, pstrb);
    wire logic [31:0] ilo_m = merge(io_lo_view[w], pwdata, pstrb);
    wire logic [31:0] ihi_m = merge(io_hi_view[w], pwdata, pstrb);

    assign sel_mem_lo[w] =
      paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::MEM_LO_IDX[w]);
    assign sel_mem_hi[w] =
      paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::MEM_HI_IDX[w]);
    assign sel_io_lo[w] =
      paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::IO_LO_IDX[w]);
    assign sel_io_hi[w] =
      paddr == cwd_pkg::cwd_byte_addr(cwd_pkg::IO_HI_IDX[w]);

    assign mem_lo_view[w] = {mem_lo_q[w], 12'h000};
    assign mem_hi_view[w] = {mem_hi_q[w], 12'h000};
    assign io_lo_view[w] = {io_lo_q[w], 2'b00};
    assign io_hi_view[w] = {16'h0000, io_hi_q[w], 2'b00};

    assign pci_mem_hit[w] = mem_on & (pci_req.addr >= mem_base) &
      (pci_req.addr <= mem_top);
    assign cb_mem_hit[w] = mem_on & (cb_req.addr >= mem_base) &
      (cb_req.addr <= mem_top);
    assign pci_io_hit[w] = io_on & (pci_req.addr >= io_base) &
      (pci_req.addr <= io_top);
    assign cb_io_hit[w] = io_on & (cb_req.addr >= io_base) &
      (cb_req.addr <= io_top);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_lo_q[w] <= cwd_pkg::MEM_RST;
        mem_hi_q[w] <= cwd_pkg::MEM_RST;
        io_lo_q[w] <= cwd_pkg::IO_LO_RST;
        io_hi_q[w] <= cwd_pkg::IO_HI_RST;
      end else if (wr_en) begin
        if (sel_mem_lo[w]) begin
          mem_lo_q[w] <= mlo_m[31:cwd_pkg::MEM_LSB];
        end
        if (sel_mem_hi[w]) begin
          mem_hi_q[w] <= mhi_m[31:cwd_pkg::MEM_LSB];
        end
        if (sel_io_lo[w]) begin
          io_lo_q[w] <= ilo_m[31:cwd_pkg::IO_LSB];
        end
        if (sel_io_hi[w]) begin
          io_hi_q[w] <=
            ihi_m[cwd_pkg::IO_HI_MSB:cwd_pkg::IO_LSB];
        end
      end
    end

    // --------------------------------------------------------------
    // window checks
    // --------------------------------------------------------------
    a_mem_off_quiet: assert property (
      !mem_on && pci_req.valid && !pci_req.is_io
      |=> !(pci_dec.fwd && pci_dec.win == 1'(w) &&
            $past(pci_mem_hit) == 2'(1 << w)))
      else $error("memory window claimed while disabled");
    a_io_off_quiet: assert property (
      !io_on |-> !pci_io_hit[w] && !cb_io_hit[w])
      else $error("io window hit while disabled");
    a_mem_top_incl: assert property (
      mem_on && pci_req.valid && !pci_req.is_io &&
      pci_req.addr[31:12] == mem_hi_q[w] &&
      mem_hi_q[w] >= mem_lo_q[w]
      |=> pci_dec.valid && pci_dec.fwd)
      else $error("memory limit page not inside window");
    a_io_top_ones: assert property (
      io_on && pci_req.valid && pci_req.is_io &&
      pci_req.addr == {io_lo_q[w][29:14], io_hi_q[w], 2'b11} &&
      io_hi_q[w] >= io_lo_q[w][13:0]
      |=> pci_dec.fwd)
      else $error("io limit low bits not taken as ones");
    a_mem_wr_take: assert property (
      wr_en && sel_mem_lo[w] && pstrb == 4'hf
      |=> mem_lo_view[w] == {$past(pwdata[31:12]), 12'h000})
      else $error("memory base write not stored");
    a_mem_hi_take: assert property (
      s_full_wr(sel_mem_hi[w])
      |=> mem_hi_view[w] == {$past(pwdata[31:12]), 12'h000})
      else $error("memory limit write not stored");
    a_io_lo_take: assert property (
      s_full_wr(sel_io_lo[w])
      |=> io_lo_view[w] == {$past(pwdata[31:2]), 2'b00})
      else $error("io base write not stored");
    a_io_hi_take: assert property (
      s_full_wr(sel_io_hi[w])
      |=> io_hi_view[w] == {16'h0000, $past(pwdata[15:2]), 2'b00})
      else $error("io limit write not stored");
    a_mem_base_incl: assert property (
      mem_on && pci_req.valid && !pci_req.is_io &&
      pci_req.addr[31:12] == mem_lo_q[w] &&
      mem_hi_q[w] >= mem_lo_q[w]
      |=> pci_dec.valid && pci_dec.fwd)
      else $error("memory base page not inside window");
    a_io_base_incl: assert property (
      io_on && pci_req.valid && pci_req.is_io &&
      pci_req.addr == {io_lo_q[w], 2'b00} &&
      io_hi_q[w] >= io_lo_q[w][13:0]
      |=> pci_dec.fwd)
      else $error("io base not inside window");
    a_cb_mem_stay: assert property (
      cb_req.valid && !cb_req.is_io && cb_mem_hit[w]
      |=> cb_dec.valid && !cb_dec.fwd)
      else $error("cardbus memory cycle inside window sent upstream");
    a_io_pci_fwd: assert property (
      pci_req.valid && pci_req.is_io && pci_io_hit[w]
      |=> pci_dec.fwd && !pci_dec.prefetchable)
      else $error("pci io cycle inside window not forwarded");
  end : g_win

  // ---------------------------------------------------------------
  // decode answers (window 0 wins when both match)
  // ---------------------------------------------------------------
  wire logic [1:0] pci_hits = pci_req.is_io ? pci_io_hit : pci_mem_hit;
  wire logic [1:0] cb_hits = cb_req.is_io ? cb_io_hit : cb_mem_hit;
  wire logic pci_win = ~pci_hits[0];
  // a cardbus cycle goes upstream only when it misses every window
  wire logic cb_up = ~|cb_hits;

  always_comb begin
    pci_dec_d.valid = pci_req.valid;
    pci_dec_d.fwd = pci_req.valid & (|pci_hits);
    pci_dec_d.win = pci_win;
    pci_dec_d.prefetchable = pci_dec_d.fwd & ~pci_req.is_io &
      pref_q[pci_win];
    cb_dec_d.valid = cb_req.valid;
    cb_dec_d.fwd = cb_req.valid & cb_up;
    cb_dec_d.win = ~cb_hits[0];
    cb_dec_d.prefetchable = cb_req.valid & ~cb_req.is_io &
      ~cb_up & pref_q[~cb_hits[0]];
  end

  // ---------------------------------------------------------------
  // read mux, taken in the setup phase so prdata is a flop
  // ---------------------------------------------------------------
  logic mapped;
  always_comb begin
    prdata_d = 32'h00000000;
    mapped = 1'b1;
    if (sel_mem_lo[0]) begin
      prdata_d = mem_lo_view[0];
    end else if (sel_mem_lo[1]) begin
      prdata_d = mem_lo_view[1];
    end else if (sel_mem_hi[0]) begin
      prdata_d = mem_hi_view[0];
    end else if (sel_mem_hi[1]) begin
      prdata_d = mem_hi_view[1];
    end else if (sel_io_lo[0]) begin
      prdata_d = io_lo_view[0];
    end else if (sel_io_lo[1]) begin
      prdata_d = io_lo_view[1];
    end else if (sel_io_hi[0]) begin
      prdata_d = io_hi_view[0];
    end else if (sel_io_hi[1]) begin
      prdata_d = io_hi_view[1];
    end else if (sel_line) begin
      prdata_d = line_view;
    end else if (sel_pin) begin
      prdata_d = pin_view;
    end else if (sel_bctl) begin
      prdata_d = bctl_view;
    end else if (sel_dctl) begin
      prdata_d = dctl_view;
    end else begin
      mapped = 1'b0;
    end
  end

  // zero wait states; unmapped access errors and writes nothing
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_q;
  assign pci_dec = pci_dec_q;
  assign cb_dec = cb_dec_q;
  assign window0_prefetchable = pref_q[0];
  assign window1_prefetchable = pref_q[1];
  assign irq_mode = mode_q;

  // ---------------------------------------------------------------
  // flops
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line_q <= cwd_pkg::IRQ_LINE_RST;
      pref_q <= cwd_pkg::PREF_RST;
      mode_q <= cwd_pkg::MODE_RST;
      prdata_q <= 32'h00000000;
      pci_dec_q <= '0;
      cb_dec_q <= '0;
    end else begin
      irq_line_q <= irq_line_d;
      pref_q <= pref_d;
      mode_q <= mode_d;
      prdata_q <= setup_ph ? prdata_d : prdata_q;
      pci_dec_q <= pci_dec_d;
      cb_dec_q <= cb_dec_d;
    end
  end

  // ---------------------------------------------------------------
  // block checks
  // ---------------------------------------------------------------
  sequence s_rd_setup(logic sel);
    setup_ph && !pwrite && sel;
  endsequence

  a_mem_low_zero: assert property (
    s_rd_setup(|{sel_mem_lo, sel_mem_hi}) ##1 access_ph
    |-> prdata[11:0] == 12'h000)
    else $error("memory window low bits not zero");
  a_io_hi_zero: assert property (
    s_rd_setup(|sel_io_hi) ##1 access_ph
    |-> prdata[31:16] == 16'h0000 && prdata[1:0] == 2'b00)
    else $error("io limit read-only bits not zero");
  a_pin_follows: assert property (
    s_rd_setup(sel_pin) ##1 access_ph
    |-> prdata[7:0] == ((mode_q == cwd_pkg::mode_isa_parallel_only) ?
                        8'h00 : 8'h01))
    else $error("interrupt pin does not follow mode");
  a_line_write: assert property (
    wr_en && sel_line && pstrb[0]
    |=> irq_line_q == $past(pwdata[7:0]) ##1
        irq_line_q == $past(irq_line_q) || $past(wr_en))
    else $error("interrupt line write lost");
  a_pref_follow: assert property (
    pci_req.valid && !pci_req.is_io && (|pci_mem_hit)
    |=> pci_dec.prefetchable == pref_q[pci_dec.win])
    else $error("prefetch type does not follow control bit");
  a_cb_inverse: assert property (
    cb_req.valid && cb_req.is_io && (|cb_io_hit) |=> !cb_dec.fwd)
    else $error("cardbus io cycle inside window sent upstream");
  a_pin_ro: assert property (
    wr_en && sel_pin |=> $stable(mode_q) && $stable(irq_line_q))
    else $error("interrupt pin write changed state");
  a_io_lo_zero: assert property (
    s_rd_setup(|sel_io_lo) ##1 access_ph
    |-> prdata[1:0] == 2'b00)
    else $error("io base low bits not zero");
  a_dec_answer: assert property (
    pci_req.valid |=> pci_dec.valid)
    else $error("pci decode answer missing");
  a_cb_up_miss: assert property (
    cb_req.valid && !cb_req.is_io && !(|cb_mem_hit) |=> cb_dec.fwd)
    else $error("cardbus memory miss not sent upstream");

endmodule : cwd_window_decode

`default_nettype wire

// ===== dv/cwd_card_model.sv
// far-side requester model: issues one decode request per go pulse
`timescale 1ns/1ps
`default_nettype none

module cwd_card_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from bench
  input wire logic go,
  input wire logic is_io,
  input wire logic [31:0] addr,
  // request towards the block
  output var cwd_pkg::cwd_req_s req
);
  // idle address toggles so a stale value never looks like a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else if (go) begin
      req <= '{valid: 1'b1, is_io: is_io, addr: addr};
    end else begin
      req <= '{valid: 1'b0, is_io: ~req.is_io, addr: ~req.addr};
    end
  end
endmodule : cwd_card_model

`default_nettype wire

// ===== dv/cwd_window_decode_tb.sv
// testbench for the cardbus window decode block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module cwd_window_decode_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, pf0, pf1, r_io = 0;
  logic [3:0] strb = 4'hf;
  logic [1:0] go = '0;
  logic [31:0] r_addr = '0;
  cwd_pkg::cwd_req_s pci_req, cb_req;
  cwd_pkg::cwd_dec_s pci_dec, cb_dec;
  cwd_pkg::cwd_irq_mode_e irq_mode;
  int bad_count = 0, n_compared = 0;

  always #2.5 pclk = ~pclk;

  cwd_window_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pci_req(pci_req), .pci_dec(pci_dec), .cb_req(cb_req), .cb_dec(cb_dec),
    .window0_prefetchable(pf0), .window1_prefetchable(pf1),
    .irq_mode(irq_mode));
  cwd_card_model host_m (.pclk(pclk), .presetn(presetn), .go(go[0]),
    .is_io(r_io), .addr(r_addr), .req(pci_req));
  cwd_card_model card_m (.pclk(pclk), .presetn(presetn), .go(go[1]),
    .is_io(r_io), .addr(r_addr), .req(cb_req));

  // ---------------------------------------------------------------
  // bus and decode tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
    // the write lands at the access edge; let it settle before looking
    @(posedge pclk);
    `CHK(e, 1'b0)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic e;
    apb(0, a, '0, q, e);
    `CHK({e, q}, {xe, x})
  endtask : rd

  task automatic dec(input logic s, input logic io, input logic [31:0] a,
                     input logic f, input logic w, input logic p);
    cwd_pkg::cwd_dec_s d;
    @(posedge pclk);
    go[s] <= 1; r_io <= io; r_addr <= a;
    @(posedge pclk);
    go[s] <= 0;
    @(posedge pclk);
    #1;
    d = s ? cb_dec : pci_dec;
    `CHK({d.valid, d.fwd}, {1'b1, f})
    if (f != s) `CHK({d.win, d.prefetchable}, {w, p})
  endtask : dec

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  logic [11:0] wa [8] = '{12'h070, 12'h080, 12'h090, 12'h0a0,
                          12'h0b0, 12'h0c0, 12'h0d0, 12'h0e0};
  logic [31:0] wm [8] = '{32'hfffff000, 32'hfffff000, 32'hfffff000,
    32'hfffff000, 32'hfffffffc, 32'h0000fffc, 32'hfffffffc, 32'h0000fffc};

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(wa[i], 32'h0, 0);
    rd(12'h0f0, 32'h000000ff, 0);
    rd(12'h0f4, 32'h00000001, 0);
    `CHK(irq_mode, cwd_pkg::mode_serial_both)
    `CHK({pf0, pf1}, 2'b11)
    dec(0, 0, 32'h00000000, 0, 0, 0);
    dec(1, 0, 32'h00000800, 1, 0, 0);
    dec(0, 1, 32'h00000000, 0, 0, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      wr(wa[i], 32'hffffffff);
      rd(wa[i], wm[i], 0);
    end
    // only the top byte lane is written; the rest must keep its value
    strb <= 4'h8;
    wr(12'h070, 32'h12345678);
    strb <= 4'hf;
    rd(12'h070, 32'h12fff000, 0);
    wr(12'h0f0, 32'h0000005a);
    rd(12'h0f0, 32'h0000005a, 0);
    wr(12'h0f4, 32'h000000ee);
    rd(12'h0f4, 32'h00000001, 0);
    rd(12'h100, 32'h0, 1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_mem();
    wr(12'h070, 32'h10000000); wr(12'h080, 32'h10001000);
    wr(12'h090, 32'h20000000); wr(12'h0a0, 32'h20000000);
    wr(12'h0f8, 32'h00000100);
    `CHK({pf0, pf1}, 2'b10)
    dec(0, 0, 32'h10000000, 1, 0, 1);
    dec(0, 0, 32'h10001fff, 1, 0, 1);
    dec(0, 0, 32'h10002000, 0, 0, 0);
    dec(0, 0, 32'h0fffffff, 0, 0, 0);
    dec(0, 0, 32'h20000ffc, 1, 1, 0);
    dec(1, 0, 32'h10000400, 0, 0, 1);
    dec(1, 0, 32'h20001000, 1, 0, 0);
    $display("test mem done");
  endtask : t_mem

  task automatic t_io();
    wr(12'h0b0, 32'h00031000); wr(12'h0c0, 32'hffff1ffc);
    wr(12'h0d0, 32'h0); wr(12'h0e0, 32'h0);
    rd(12'h0c0, 32'h00001ffc, 0);
    dec(0, 1, 32'h00031fff, 1, 0, 0);
    dec(0, 1, 32'h00032000, 0, 0, 0);
    dec(0, 1, 32'h00021800, 0, 0, 0);
    dec(0, 1, 32'h00000000, 0, 0, 0);
    dec(0, 0, 32'h00031800, 0, 0, 0);
    dec(1, 1, 32'h00031000, 0, 0, 0);
    dec(1, 1, 32'h00030ffc, 1, 0, 0);
    $display("test io done");
  endtask : t_io

  task automatic t_mode();
    wr(12'h248, 32'h00000000);
    `CHK(irq_mode, cwd_pkg::mode_isa_parallel_only)
    rd(12'h0f4, 32'h00000000, 0);
    wr(12'h248, 32'h00000002);
    `CHK(irq_mode, cwd_pkg::mode_parallel_both)
    rd(12'h0f4, 32'h00000001, 0);
    wr(12'h248, 32'h00000004);
    `CHK(irq_mode, cwd_pkg::mode_serial_isa_parallel_pci)
    rd(12'h0f4, 32'h00000001, 0);
    $display("test mode done");
  endtask : t_mode

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_regs();
    t_mem();
    t_io();
    t_mode();
    // a second reset in mid-run must bring every register back
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset();
    finish_test();
  end
endmodule : cwd_window_decode_tb

`default_nettype wire
